// ### hdl/intc_arbiter.sv
`timescale 1ns/100ps

// ==========================================================
// Combinational acceptance and priority selection.
// ==========================================================
module intc_arbiter
    import intc_pkg::*;
(
    input wire logic nmi,
    input wire logic [num_src-1:0] req,
    input wire logic [num_src-1:0] level,
    input wire logic [3*num_src-1:0] prio,
    input wire ctl_mode_e mode,
    input wire core_mask_s cmask,
    output winner_s win
);

    // Acceptance per source from mode, control level, priority and masks.
    function automatic logic accept(input ctl_mode_e m, input logic lvl,
                                    input logic [2:0] p, input core_mask_s c);
        logic ok;
        ok = 1'b0;
        unique case (m)
            mode_0: ok = !c.gmask;
            mode_1: ok = lvl ? !(c.gmask && c.umask) : !c.gmask;
            mode_2: ok = p > c.mask_level_field;
            mode_3: ok = (lvl ? !(c.gmask && c.umask) : !c.gmask)
                         && p > c.mask_level_field;
        endcase
        return ok;
    endfunction

    // Vector number for a source index, external lines first.
    function automatic logic [vec_w-1:0] vec_of(input int unsigned i);
        return vec_ext_base + vec_w'(i);
    endfunction

    logic [vec_w-1:0] best_vec;
    logic [3:0] best_key;
    logic best_ok;
    logic [3:0] key;

    // Highest key wins; ties go to the lowest vector because scanning descends.
    always_comb
    begin
        best_vec = '0;
        best_key = '0;
        best_ok = 1'b0;
        key = '0;
        for (int i = num_src - 1; i >= 0; i--)
        begin
            if (mode == mode_0 || mode == mode_1)
                key = {3'h0, level[i]};
            else if (mode == mode_2)
                key = {1'b0, prio[3*i +: 3]};
            else
                key = {prio[3*i +: 3], level[i]};
            if (req[i] && accept(mode, level[i], prio[3*i +: 3], cmask)
                && (!best_ok || key >= best_key))
            begin
                best_ok = 1'b1;
                best_key = key;
                best_vec = vec_of(i);
            end
        end
        // The non-maskable input overrides everything.
        if (nmi)
        begin
            win.valid = 1'b1;
            win.vector = vec_nmi;
        end
        else
        begin
            win.valid = best_ok;
            win.vector = best_vec;
        end
    end

endmodule

// ### hdl/intc_sync.sv
`timescale 1ns/100ps

// ==========================================================
// Three-stage synchroniser with agreement of the last two stages.
// ==========================================================
module intc_sync
    import intc_pkg::*;
#(
    parameter int unsigned w = 9
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [w-1:0] din,
    output logic [w-1:0] dout
);

    logic [w-1:0] s1_reg;
    logic [w-1:0] s2_reg;
    logic [w-1:0] s3_reg;

    // The first stage only feeds the second to keep metastability contained.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end
        else
        begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A bit changes only once the second and third stages agree.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dout <= '0;
        else
            dout <= (s2_reg & s3_reg) | (dout & (s2_reg | s3_reg));
    end

endmodule

// ### hdl/priority_interrupt_controller.sv
`timescale 1ns/100ps

module priority_interrupt_controller
    import intc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic nmi_pin,
    input wire logic [num_ext-1:0] external_request_lines,
    input wire logic [num_int-1:0] periph_req,
    input wire logic core_boundary,
    input wire logic core_saved,
    output logic take_req,
    output logic save_req,
    output logic fetch_req,
    output logic [vec_w-1:0] vector_num,
    output logic [addr_w-1:0] vector_addr,
    output logic wide_entry,
    output logic irq
);

    // ==========================================================
    // Registers and internal state.
    // ==========================================================
    logic [2:0] system_control_reg;
    logic [num_src-1:0] control_level_reg;
    logic [3*num_src-1:0] priority_level_reg;
    logic condition_code_gmask;
    logic user_mask_bit;
    logic trace_bit;
    logic [2:0] mask_level_field;
    logic [ev_w-1:0] ev_stat_reg;
    logic [ev_w-1:0] ev_mask_reg;
    take_state_e state_reg;
    logic [vec_w-1:0] held_vec_reg;
    logic [2:0] held_prio_reg;
    logic held_lvl_reg;

    logic [num_ext:0] pins_sync;
    logic nmi_sync;
    logic nmi_prev_reg;
    logic nmi_latch_reg;
    logic [num_src-1:0] req_all;
    ctl_mode_e mode;
    core_mask_s cmask;
    winner_s win;
    core_mask_s condition_code_reg;
    logic [31:0] extended_control_reg;

    logic wr_en;
    logic rd_en;
    logic ev_taken_pulse;
    logic ev_nmi_pulse;
    logic [ev_w-1:0] ev_set;
    logic [31:0] rd_word;
    logic rd_ok;

    // Byte address of a table entry for a vector and entry size.
    function automatic logic [addr_w-1:0] table_addr(input logic [vec_w-1:0] v,
                                                     input logic wide);
        if (wide)
            return {1'b0, v, 2'h0};
        else
            return {2'h0, v, 1'b0};
    endfunction

    // Select bit decoding; mode 1 needs the high bit clear, both bits set give mode 3.
    function automatic ctl_mode_e decode_mode(input logic hi, input logic lo);
        if (lo)
            return hi ? mode_3 : mode_1;
        else
            return hi ? mode_2 : mode_0;
    endfunction

    // ==========================================================
    // Input synchronisation.
    // ==========================================================
    intc_sync #(.w(num_ext + 1)) u_sync
    (
        .pclk(pclk),
        .presetn(presetn),
        .din({nmi_pin, external_request_lines}),
        .dout(pins_sync)
    );

    assign nmi_sync = pins_sync[num_ext];
    assign req_all = {periph_req, pins_sync[num_ext-1:0]};
    assign mode = decode_mode(system_control_reg[sys_mode_hi_bit],
                              system_control_reg[sys_mode_lo_bit]);
    assign cmask.gmask = condition_code_gmask;
    assign cmask.umask = user_mask_bit;
    assign cmask.mask_level_field = mask_level_field;
    assign condition_code_reg = cmask;
    assign extended_control_reg = {29'h0, mask_level_field};

    // The non-maskable input is edge triggered so a held level fires once.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nmi_prev_reg <= 1'b0;
            nmi_latch_reg <= 1'b0;
        end
        else
        begin
            nmi_prev_reg <= nmi_sync;
            if (nmi_sync && !nmi_prev_reg)
                nmi_latch_reg <= 1'b1;
            else if (state_reg == st_fetch && held_vec_reg == vec_nmi)
                nmi_latch_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Arbitration.
    // ==========================================================
    intc_arbiter u_arb
    (
        .nmi(nmi_latch_reg),
        .req(req_all),
        .level(control_level_reg),
        .prio(priority_level_reg),
        .mode(mode),
        .cmask(cmask),
        .win(win)
    );

    // ==========================================================
    // Take sequence.
    // ==========================================================
    // A winner is taken at an instruction boundary, state saved, then the vector fetched.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= st_idle;
            held_vec_reg <= '0;
        end
        else
        begin
            unique case (state_reg)
                st_idle:
                    if (win.valid)
                        state_reg <= st_wait;
                st_wait:
                    if (!win.valid)
                        state_reg <= st_idle;
                    else if (core_boundary)
                    begin
                        held_vec_reg <= win.vector;
                        state_reg <= st_save;
                    end
                st_save:
                    if (core_saved)
                        state_reg <= st_fetch;
                st_fetch:
                    state_reg <= st_idle;
            endcase
        end
    end

    // Remember the priority of the taken source to raise the mask to it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            held_prio_reg <= '0;
            held_lvl_reg <= 1'b0;
        end
        else if (state_reg == st_wait && core_boundary && win.valid)
        begin
            held_prio_reg <= '0;
            held_lvl_reg <= 1'b0;
            for (int i = 0; i < num_src; i++)
                if (win.vector == vec_ext_base + vec_w'(i))
                begin
                    held_prio_reg <= priority_level_reg[3*i +: 3];
                    held_lvl_reg <= control_level_reg[i];
                end
        end
    end

    // Core-facing outputs, all registered.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            take_req <= 1'b0;
            save_req <= 1'b0;
            fetch_req <= 1'b0;
            vector_num <= '0;
            vector_addr <= '0;
            wide_entry <= 1'b0;
        end
        else
        begin
            take_req <= state_reg == st_wait && core_boundary && win.valid;
            save_req <= state_reg == st_save && !core_saved;
            fetch_req <= state_reg == st_save && core_saved;
            vector_num <= held_vec_reg;
            vector_addr <= table_addr(held_vec_reg, system_control_reg[sys_wide_bit]);
            wide_entry <= system_control_reg[sys_wide_bit];
        end
    end

    // ==========================================================
    // APB slave: zero wait states, unmapped reads give zero.
    // ==========================================================
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign ev_taken_pulse = state_reg == st_save && core_saved;
    assign ev_nmi_pulse = nmi_sync && !nmi_prev_reg;
    assign ev_set = {ev_nmi_pulse, ev_taken_pulse};

    // Mode, entry size and control levels.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            system_control_reg <= '0;
            control_level_reg <= '0;
            priority_level_reg <= '0;
        end
        else if (wr_en)
        begin
            if (paddr == off_sysctl)
                system_control_reg <= pwdata[2:0];
            for (int w = 0; w < level_words; w++)
                if (paddr == off_level_base + 12'(4 * w))
                    for (int b = 0; b < 32; b++)
                        if (32 * w + b < num_src)
                            control_level_reg[32 * w + b] <= pwdata[b];
            for (int w = 0; w < prio_words; w++)
                if (paddr == off_prio_base + 12'(4 * w))
                    for (int s = 0; s < 8; s++)
                        if (8 * w + s < num_src)
                            priority_level_reg[3*(8*w+s) +: 3] <= pwdata[4*s +: 3];
        end
    end

    // Core mask state; taking an interrupt raises the masks that its mode applies to the taken source and drops trace.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            condition_code_gmask <= 1'b1;
            user_mask_bit <= 1'b0;
            trace_bit <= 1'b0;
            mask_level_field <= 3'h7;
        end
        else if (ev_taken_pulse && held_vec_reg != vec_nmi)
        begin
            trace_bit <= 1'b0;
            if (mode == mode_2 || mode == mode_3)
                mask_level_field <= held_prio_reg;
            if (mode != mode_2)
            begin
                condition_code_gmask <= 1'b1;
                if ((mode == mode_1 || mode == mode_3) && held_lvl_reg)
                    user_mask_bit <= 1'b1;
            end
        end
        else if (ev_taken_pulse)
        begin
            trace_bit <= 1'b0;
            mask_level_field <= 3'h7;
            condition_code_gmask <= 1'b1;
        end
        else if (wr_en && paddr == off_core)
        begin
            condition_code_gmask <= pwdata[core_gmask_bit];
            user_mask_bit <= pwdata[core_umask_bit];
            trace_bit <= pwdata[core_trace_bit];
            mask_level_field <= pwdata[core_lvl_lsb +: 3];
        end
    end

    // Sticky events; a new event beats a clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ev_stat_reg <= '0;
            ev_mask_reg <= '0;
        end
        else
        begin
            if (wr_en && paddr == off_irq_stat)
                ev_stat_reg <= (ev_stat_reg & ~pwdata[ev_w-1:0]) | ev_set;
            else
                ev_stat_reg <= ev_stat_reg | ev_set;
            if (wr_en && paddr == off_irq_mask)
                ev_mask_reg <= pwdata[ev_w-1:0];
        end
    end

    // Read decode.
    always_comb
    begin
        rd_word = '0;
        rd_ok = 1'b1;
        unique case (paddr)
            off_sysctl: rd_word = {29'h0, system_control_reg};
            off_core:
            begin
                rd_word[core_gmask_bit] = condition_code_gmask;
                rd_word[core_umask_bit] = user_mask_bit;
                rd_word[core_trace_bit] = trace_bit;
                rd_word[core_lvl_lsb +: 3] = extended_control_reg[2:0];
                rd_word[core_busy_bit] = state_reg != st_idle;
                rd_word[core_ack_bit] = condition_code_reg.gmask;
            end
            off_status:
            begin
                rd_word[stat_vec_lsb +: vec_w] = held_vec_reg;
                rd_word[stat_pend_bit] = win.valid;
                rd_word[stat_state_lsb +: 2] = state_reg;
                rd_word[stat_addr_lsb +: addr_w] =
                    table_addr(held_vec_reg, system_control_reg[sys_wide_bit]);
            end
            off_irq_stat: rd_word = {30'h0, ev_stat_reg};
            off_irq_mask: rd_word = {30'h0, ev_mask_reg};
            default:
            begin
                rd_ok = 1'b0;
                for (int w = 0; w < level_words; w++)
                    if (paddr == off_level_base + 12'(4 * w))
                    begin
                        rd_ok = 1'b1;
                        for (int b = 0; b < 32; b++)
                            if (32 * w + b < num_src)
                                rd_word[b] = control_level_reg[32 * w + b];
                    end
                for (int w = 0; w < prio_words; w++)
                    if (paddr == off_prio_base + 12'(4 * w))
                    begin
                        rd_ok = 1'b1;
                        for (int s = 0; s < 8; s++)
                            if (8 * w + s < num_src)
                                rd_word[4*s +: 3] = priority_level_reg[3*(8*w+s) +: 3];
                    end
            end
        endcase
    end

    // Read data is captured in the setup cycle so it stands in the access phase.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            if (rd_en)
                prdata <= rd_ok ? rd_word : slverr_none;
            pready <= psel && !penable;
            pslverr <= 1'b0;
            irq <= |(ev_stat_reg & ev_mask_reg);
        end
    end

endmodule

// ### include/intc_pkg.sv
package intc_pkg;

    // ==========================================================
    // Widths and source counts.
    // ==========================================================
    localparam int unsigned num_ext = 8;
    localparam int unsigned num_int = 80;
    localparam int unsigned num_src = num_ext + num_int;
    localparam int unsigned vec_w = 7;
    localparam int unsigned addr_w = 10;

    // ==========================================================
    // Vector numbers.
    // ==========================================================
    localparam logic [vec_w-1:0] vec_nmi = 7'h07;
    localparam logic [vec_w-1:0] vec_ext_base = 7'h10;
    localparam logic [vec_w-1:0] vec_int_base = 7'h18;
    localparam logic [vec_w-1:0] vec_int_last = 7'h67;

    // ==========================================================
    // APB register map (byte offsets).
    // ==========================================================
    localparam logic [11:0] off_sysctl = 12'h000;
    localparam logic [11:0] off_core = 12'h004;
    localparam logic [11:0] off_status = 12'h008;
    localparam logic [11:0] off_irq_stat = 12'h00c;
    localparam logic [11:0] off_irq_mask = 12'h010;
    localparam logic [11:0] off_level_base = 12'h020;
    localparam logic [11:0] off_prio_base = 12'h040;
    localparam int unsigned level_words = 3;
    localparam int unsigned prio_words = 11;

    // Field positions.
    localparam int unsigned sys_mode_lo_bit = 0;
    localparam int unsigned sys_mode_hi_bit = 1;
    localparam int unsigned sys_wide_bit = 2;
    localparam int unsigned core_gmask_bit = 0;
    localparam int unsigned core_umask_bit = 1;
    localparam int unsigned core_trace_bit = 2;
    localparam int unsigned core_lvl_lsb = 4;
    localparam int unsigned core_busy_bit = 8;
    localparam int unsigned core_ack_bit = 9;
    localparam int unsigned stat_vec_lsb = 0;
    localparam int unsigned stat_pend_bit = 8;
    localparam int unsigned stat_state_lsb = 12;
    localparam int unsigned stat_addr_lsb = 16;

    // Event bits in the sticky status.
    localparam int unsigned ev_taken = 0;
    localparam int unsigned ev_nmi = 1;
    localparam int unsigned ev_w = 2;

    localparam logic [31:0] slverr_none = 32'h0000_0000;

    // ==========================================================
    // Types.
    // ==========================================================
    typedef enum logic [1:0]
    {
        mode_0 = 2'h0,
        mode_1 = 2'h1,
        mode_2 = 2'h2,
        mode_3 = 2'h3
    } ctl_mode_e;

    typedef enum logic [1:0]
    {
        st_idle = 2'h0,
        st_wait = 2'h1,
        st_save = 2'h3,
        st_fetch = 2'h2
    } take_state_e;

    // Core mask state that the arbiter reads.
    typedef struct packed
    {
        logic gmask;
        logic umask;
        logic [2:0] mask_level_field;
    } core_mask_s;

    // Winning request.
    typedef struct packed
    {
        logic valid;
        logic [vec_w-1:0] vector;
    } winner_s;

endpackage

// ### verification/core_model.sv
`timescale 1ns/100ps

// ==========================================================
// Processor core as seen by the controller.
// ==========================================================
module core_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic save_req,
    output logic core_boundary,
    output logic core_saved
);
    logic [1:0] phase_reg;

    // Free-running phase, so the stack push takes a varying time.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_reg <= 2'h0;
        end
        else
        begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    // Instructions end every other cycle; saving only ever follows a request.
    assign core_boundary = phase_reg[0];
    assign core_saved = save_req && (phase_reg == 2'h3);
endmodule

// ### verification/intc_properties.sv
`timescale 1ns/100ps

// ==========================================================
// Handshake and vector checks at the controller's ports.
// ==========================================================
module intc_properties
    import intc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic core_boundary,
    input wire logic core_saved,
    input wire logic take_req,
    input wire logic save_req,
    input wire logic fetch_req,
    input wire logic [vec_w-1:0] vector_num,
    input wire logic [addr_w-1:0] vector_addr,
    input wire logic wide_entry
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A save that the core has finished must lead straight to the fetch.
    sequence s_saved;
        save_req && core_saved;
    endsequence

    a_fetch_after_save: assert property (s_saved |=> fetch_req)
        else $error("fetch did not follow save");
    a_take_at_end: assert property (take_req |-> $past(core_boundary))
        else $error("take without boundary");
    // The save request is registered, so it rises the cycle after the take.
    a_take_saves: assert property (take_req && !core_saved |=> save_req)
        else $error("take without save");
    a_save_held: assert property (save_req && !core_saved |=> save_req)
        else $error("save dropped early");
    a_fetch_pulse: assert property (fetch_req |=> !fetch_req)
        else $error("fetch longer than one cycle");
    a_wide_addr: assert property (fetch_req && wide_entry |->
        vector_addr == {1'b0, vector_num, 2'b00})
        else $error("wide address wrong");
    a_narrow_addr: assert property (fetch_req && !wide_entry |->
        vector_addr == {2'b00, vector_num, 1'b0})
        else $error("narrow address wrong");
    a_vector_legal: assert property (fetch_req |-> vector_num == vec_nmi ||
        vector_num inside {[vec_ext_base:vec_int_last]})
        else $error("vector out of range");
endmodule

// ### verification/tb_top.sv
`timescale 1ns/100ps

// ==========================================================
// Self-checking bench.
// ==========================================================
module tb_top
    import intc_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, nmi_pin = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, core_boundary, core_saved, take_req, save_req, fetch_req;
    logic wide_entry, irq;
    logic [7:0] ext = 8'h00;
    logic [79:0] periph = 80'h0;
    logic [6:0] vector_num;
    logic [9:0] vector_addr;
    int miscompares = 0, compares = 0, cyc = 0;

    priority_interrupt_controller u_priority_interrupt_controller (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .nmi_pin(nmi_pin), .external_request_lines(ext),
        .periph_req(periph), .core_boundary(core_boundary), .core_saved(core_saved),
        .take_req(take_req), .save_req(save_req), .fetch_req(fetch_req),
        .vector_num(vector_num), .vector_addr(vector_addr), .wide_entry(wide_entry),
        .irq(irq));
    core_model u_core_model (.pclk(pclk), .presetn(presetn), .save_req(save_req),
        .core_boundary(core_boundary), .core_saved(core_saved));

    // Clock and a hang limit well above the longest expected run.
    initial
    begin
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            final_report();
        end
    end

    task automatic final_report();
        if (miscompares == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic ok);
        compares++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("MISMATCH %0t value %h", $time, q);
        end
    endtask

    // One bus transfer; pready and read data are taken at the same rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Waits for a fetch; a zero vector means none may come.
    task automatic expect_vec(input logic [6:0] v);
        int i;
        i = 0;
        @(negedge pclk);
        while (fetch_req !== 1'b1 && i < 60)
        begin
            @(negedge pclk);
            i++;
        end
        q = {25'h0, vector_num};
        chk((v == 7'h00) ? (i == 60) : (i < 60 && vector_num === v));
        // Later stimulus must start on a rising edge.
        @(posedge pclk);
    endtask

    // Reset value of the mask word, then an unmapped read after it.
    task automatic test_regs();
        apb(1'b0, off_core, 32'h0);
        chk(q === 32'h0000_0271);
        apb(1'b0, 12'h100, 32'h0);
        chk(q === 32'h0 && pslverr === 1'b0);
    endtask

    // Non-maskable edge with wide entries, then the event interrupt.
    task automatic test_nmi();
        apb(1'b1, off_sysctl, 32'h4);
        nmi_pin <= 1'b1;
        expect_vec(7'h07);
        nmi_pin <= 1'b0;
        apb(1'b1, off_irq_mask, 32'h3);
        repeat (2) @(negedge pclk);
        chk(irq);
        apb(1'b1, off_irq_stat, 32'h3);
        repeat (2) @(negedge pclk);
        chk(!irq);
    endtask

    // Mode 0: global mask and control level order.
    task automatic test_mode0();
        apb(1'b1, off_sysctl, 32'h0);
        apb(1'b1, off_level_base, 32'h20);
        ext <= 8'h21;
        expect_vec(7'h00);
        apb(1'b1, off_core, 32'h0);
        expect_vec(7'd21);
        ext <= 8'h00;
        apb(1'b0, off_core, 32'h0);
        chk(q === 32'h0000_0201);
    endtask

    // Mode 1: level 0 needs the global mask clear, level 1 either mask.
    task automatic test_mode1();
        apb(1'b1, off_sysctl, 32'h1);
        apb(1'b1, off_core, 32'h1);
        ext <= 8'h01;
        expect_vec(7'h00);
        ext <= 8'h21;
        expect_vec(7'd21);
        ext <= 8'h00;
        apb(1'b0, off_core, 32'h0);
        chk(q === 32'h0000_0203);
    endtask

    // Mode 2: priority strictly above the mask level.
    task automatic test_mode2();
        apb(1'b1, off_sysctl, 32'h2);
        apb(1'b1, off_prio_base + 12'h004, 32'h5);
        apb(1'b1, off_core, 32'h50);
        periph <= 80'h1;
        expect_vec(7'h00);
        apb(1'b1, off_core, 32'h41);
        expect_vec(7'd24);
    endtask

    // Mode 3: priority combined with the global mask.
    task automatic test_mode3();
        apb(1'b1, off_sysctl, 32'h3);
        apb(1'b1, off_core, 32'h1);
        expect_vec(7'h00);
        apb(1'b1, off_core, 32'h0);
        expect_vec(7'd24);
        periph <= 80'h0;
    endtask

    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_nmi();
        test_mode0();
        test_mode1();
        test_mode2();
        test_mode3();
        final_report();
    end
endmodule

bind priority_interrupt_controller intc_properties u_intc_properties (.pclk(pclk),
    .presetn(presetn), .core_boundary(core_boundary), .core_saved(core_saved),
    .take_req(take_req), .save_req(save_req), .fetch_req(fetch_req),
    .vector_num(vector_num), .vector_addr(vector_addr), .wide_entry(wide_entry));
